// file: dccr_channel.sv
// one peripheral dma channel: pointer, count, reload and control
// assumes a single ahb-lite master and peripherals on hclk
`timescale 1ns/100ps
`include "dccr_consts.svh"
module dccr_channel import dccr_pkg::*; #(
    parameter int NPER = 8,
    parameter int PSEL_W = 3,
    parameter logic [31:0] HOLD_BASE = 32'h4000_0000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NPER-1:0] per_req,
    output logic [NPER-1:0] per_ack,
    output logic xfer_valid,
    output dccr_xfer_t xfer_req,
    input wire logic xfer_done,
    input wire logic xfer_err,
    output logic irq
);
    // refuse widths the selector cannot address
    if (NPER < 1 || PSEL_W < 1 || PSEL_W > 16 || (1 << PSEL_W) < NPER) begin : g_bad
        $error("dccr_channel: PSEL_W too small for NPER");
    end

    // pointer step for a size code; reserved code steps a word
    function automatic logic [31:0] size_step(input logic [1:0] sz);
        case (sz)
            `DCCR_SZ_BYTE: size_step = 32'h0000_0001;
            `DCCR_SZ_HALF: size_step = 32'h0000_0002;
            default: size_step = 32'h0000_0004;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////
    // state
    logic [31:0] ptr_r; // memory_pointer_reg
    logic [PSEL_W-1:0] psel_r; // peripheral_selector
    logic [15:0] count_r; // remaining_count
    logic [31:0] raddr_r; // address_reload_value
    logic [15:0] rcount_r; // count_reload_value
    logic ring_r; // keep reload values
    logic [1:0] size_r; // item size code
    logic enabled_r; // transfer_go state
    logic fault_r; // transfer_fault_flag
    dccr_state_t state_r; // sequencer
    logic [PSEL_W-1:0] hs_r; // line served by the open item
    dccr_aphase_t ap_r; // pending data phase
    logic [31:0] hrdata_r;
    logic hready_r;
    logic [NPER-1:0] ack_r;
    logic xvalid_r;
    dccr_xfer_t xreq_r;
    logic [`DCCR_EV_W-1:0] istat;
    logic [`DCCR_EV_W-1:0] imask;
    logic irq_w;

    ////////////////////////////////////////////////////////////
    // bus decode
    wire take = hsel && htrans[1] && hready;
    wire wr_ptr = ap_r.wr && ap_r.addr == `DCCR_OFF_PTR;
    wire wr_psel = ap_r.wr && ap_r.addr == `DCCR_OFF_PSEL;
    wire wr_cnt = ap_r.wr && ap_r.addr == `DCCR_OFF_CNT;
    wire wr_raddr = ap_r.wr && ap_r.addr == `DCCR_OFF_RADDR;
    wire wr_rcnt = ap_r.wr && ap_r.addr == `DCCR_OFF_RCNT;
    wire wr_ctl = ap_r.wr && ap_r.addr == `DCCR_OFF_CTL;
    wire wr_mode = ap_r.wr && ap_r.addr == `DCCR_OFF_MODE;
    wire wr_istat = ap_r.wr && ap_r.addr == `DCCR_OFF_ISTAT;
    wire wr_imask = ap_r.wr && ap_r.addr == `DCCR_OFF_IMASK;
    // control strobes, each only on a written one
    wire go_w = wr_ctl && hwdata[`DCCR_CTL_GO];
    wire stop_w = wr_ctl && hwdata[`DCCR_CTL_STOP];
    wire error_clear_w = wr_ctl && hwdata[`DCCR_CTL_ERROR_CLEAR];

    // read mux; control and unmapped words read as zero
    wire [31:0] stat_w = {29'h0, state_r == DCCR_BUSY, fault_r, enabled_r};
    wire [31:0] rd_mux =
        ap_r.addr == `DCCR_OFF_PTR ? ptr_r :
        ap_r.addr == `DCCR_OFF_PSEL ? 32'(psel_r) :
        ap_r.addr == `DCCR_OFF_CNT ? {16'h0, count_r} :
        ap_r.addr == `DCCR_OFF_RADDR ? raddr_r :
        ap_r.addr == `DCCR_OFF_RCNT ? {16'h0, rcount_r} :
        ap_r.addr == `DCCR_OFF_MODE ? {28'h0, ring_r, 1'b0, size_r} :
        ap_r.addr == `DCCR_OFF_STAT ? stat_w :
        ap_r.addr == `DCCR_OFF_ISTAT ? 32'(istat) :
        ap_r.addr == `DCCR_OFF_IMASK ? 32'(imask) :
        `DCCR_RST_WORD;

    ////////////////////////////////////////////////////////////
    // ahb-lite slave: writes zero-wait, reads take one wait state
    // the wait lets a write just ahead of a read land before sampling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_r <= '0;
            hready_r <= 1'b1;
            hrdata_r <= `DCCR_RST_WORD;
        end else begin
            ap_r <= '{wr: take && hwrite, rd: take && !hwrite, addr: haddr[7:0]};
            hready_r <= !(take && !hwrite);
            if (ap_r.rd) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // peripheral selector decode
    logic [PSEL_W-1:0] hs_idx;
    logic to_periph;
    logic [31:0] hold_addr;
    logic map_ok;
    dccr_pmap #(.NPER(NPER), .PSEL_W(PSEL_W), .HOLD_BASE(HOLD_BASE)) u_pmap (
        .sel(psel_r),
        .hs_idx(hs_idx),
        .to_periph(to_periph),
        .hold_addr(hold_addr),
        .ok(map_ok)
    );

    ////////////////////////////////////////////////////////////
    // channel conditions
    wire idle = state_r == DCCR_IDLE;
    // empty count with a pending reload, taken only while idle
    wire need_rld = idle && count_r == 16'h0 && rcount_r != 16'h0;
    // start needs enable, no fault, items left and a request
    wire can_go = idle && enabled_r && !fault_r && map_ok && count_r != 16'h0
        && per_req[hs_idx];
    wire item_ok = !idle && xfer_done && !xfer_err;
    wire item_err = !idle && xfer_done && xfer_err;

    // next values; a bus write wins over the hardware update, except on the fault flag
    wire [31:0] ptr_nxt = wr_ptr ? hwdata :
        need_rld ? raddr_r :
        item_ok ? ptr_r + size_step(size_r) : ptr_r;
    wire [15:0] count_nxt = wr_cnt ? hwdata[15:0] :
        need_rld ? rcount_r :
        item_ok ? count_r - 16'h1 : count_r;
    // ring mode keeps both reload values for the next lap
    wire [31:0] raddr_nxt = wr_raddr ? hwdata :
        (need_rld && !ring_r) ? `DCCR_RST_WORD : raddr_r;
    wire [15:0] rcount_nxt = wr_rcnt ? hwdata[15:0] :
        (need_rld && !ring_r) ? `DCCR_RST_CNT : rcount_r;
    // stop beats go when both are written together
    wire enabled_nxt = stop_w ? 1'b0 : (go_w ? 1'b1 : enabled_r);
    // a new fault beats the clear in the same cycle
    wire fault_nxt = item_err || (fault_r && !error_clear_w);

    ////////////////////////////////////////////////////////////
    // software-visible registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_r <= `DCCR_RST_WORD;
            psel_r <= '0;
            count_r <= `DCCR_RST_CNT;
            raddr_r <= `DCCR_RST_WORD;
            rcount_r <= `DCCR_RST_CNT;
            ring_r <= 1'b0;
            size_r <= `DCCR_SZ_BYTE;
            enabled_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            ptr_r <= ptr_nxt;
            count_r <= count_nxt;
            raddr_r <= raddr_nxt;
            rcount_r <= rcount_nxt;
            enabled_r <= enabled_nxt;
            fault_r <= fault_nxt;
            if (wr_psel) begin
                psel_r <= hwdata[PSEL_W-1:0];
            end
            if (wr_mode) begin
                ring_r <= hwdata[`DCCR_MODE_RING];
                size_r <= hwdata[`DCCR_MODE_SIZE_LO +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // item sequencer: one request in flight at a time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= DCCR_IDLE;
            xvalid_r <= 1'b0;
            xreq_r <= '0;
            hs_r <= '0;
            ack_r <= '0;
        end else begin
            ack_r <= '0;
            case (state_r)
                DCCR_IDLE: begin
                    // freeze the item so later register writes cannot tear it
                    if (can_go) begin
                        xreq_r <= '{mem_addr: ptr_r, hold_addr: hold_addr,
                            size: size_r, to_periph: to_periph};
                        hs_r <= hs_idx;
                        xvalid_r <= 1'b1;
                        state_r <= DCCR_BUSY;
                    end
                end
                DCCR_BUSY: begin
                    // acknowledge the peripheral line once the item ends
                    if (xfer_done) begin
                        xvalid_r <= 1'b0;
                        ack_r <= NPER'(1) << hs_r;
                        state_r <= DCCR_IDLE;
                    end
                end
                default: begin
                    state_r <= DCCR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // events and interrupt line
    wire [`DCCR_EV_W-1:0] ev = {item_err, need_rld, item_ok && count_r == 16'h1};
    dccr_irq u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .ev(ev),
        .clr_we(wr_istat),
        .mask_we(wr_imask),
        .wdata(hwdata[`DCCR_EV_W-1:0]),
        .stat_r(istat),
        .mask_r(imask),
        .irq_r(irq_w)
    );

    // all outputs come from flip-flops except hresp, which is tied low
    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = 1'b0;
    assign per_ack = ack_r;
    assign xfer_valid = xvalid_r;
    assign xfer_req = xreq_r;
    assign irq = irq_w;

    ////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ptr_next;
        $rose(xvalid_r) |-> xreq_r.mem_addr == $past(ptr_r);
    endproperty
    a_ptr_next: assert property (p_ptr_next) else $error("item address not pointer");

    property p_hold_sel;
        can_go |=> xreq_r.hold_addr == $past(hold_addr) && hs_r == $past(psel_r);
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("selector not applied");

    property p_psel_low;
        wr_psel |=> psel_r == $past(hwdata[PSEL_W-1:0]);
    endproperty
    a_psel_low: assert property (p_psel_low) else $error("selector field wrong");

    property p_cnt_dec;
        item_ok && !wr_cnt |=> count_r == $past(count_r) - 16'h1;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) else $error("count not decremented");

    property p_rld_ptr;
        need_rld && !wr_ptr |=> ptr_r == $past(raddr_r);
    endproperty
    a_rld_ptr: assert property (p_rld_ptr) else $error("pointer not reloaded");

    property p_rld_cnt;
        need_rld && !wr_cnt |=> count_r == $past(rcount_r) ##1 count_r != 16'h0 || !idle;
    endproperty
    a_rld_cnt: assert property (p_rld_cnt) else $error("count not reloaded");

    property p_empty_stop;
        idle && count_r == 16'h0 |=> !xvalid_r;
    endproperty
    a_empty_stop: assert property (p_empty_stop) else $error("transfer on empty count");

    property p_rld_clr;
        need_rld && !ring_r && !wr_rcnt |=> rcount_r == 16'h0;
    endproperty
    a_rld_clr: assert property (p_rld_clr) else $error("reload count kept");

    property p_go_stop;
        wr_ctl |=> enabled_r == ($past(hwdata[`DCCR_CTL_STOP]) ? 1'b0 :
            ($past(hwdata[`DCCR_CTL_GO]) ? 1'b1 : $past(enabled_r)));
    endproperty
    a_go_stop: assert property (p_go_stop) else $error("enable bit wrong");

    property p_error_clear;
        error_clear_w && !item_err |=> !fault_r;
    endproperty
    a_error_clear: assert property (p_error_clear) else $error("fault not cleared");

    property p_ring_keep;
        need_rld && ring_r && !wr_rcnt && !wr_raddr |=> $stable(rcount_r) && $stable(raddr_r);
    endproperty
    a_ring_keep: assert property (p_ring_keep) else $error("ring reload lost");

    property p_ptr_step;
        item_ok && !wr_ptr |=> ptr_r - $past(ptr_r) ==
            ($past(size_r) == 2'h0 ? 32'h1 : $past(size_r) == 2'h1 ? 32'h2 : 32'h4);
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");

    property p_ctl_zero;
        ap_r.rd && ap_r.addr == `DCCR_OFF_CTL |=> hrdata_r == 32'h0 && hready_r;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("control read not zero");

    c_item: cover property (can_go ##[1:20] item_ok);
    c_reload: cover property (item_ok && count_r == 16'h1 ##[1:4] need_rld);
    c_fault_clr: cover property (item_err ##[1:40] error_clear_w);
endmodule

// file: dccr_channel_tb.sv
// self-checking bench for one dma channel behind an ahb-lite slave port
// assumes dccr_pkg, dccr_consts.svh and the mover model are compiled first
`timescale 1ns/100ps
`include "dccr_consts.svh"
module dccr_channel_tb import dccr_pkg::*; ;
    `define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
        $display("Error %s expected %h seen %h", nm, exp, got); end end
    ////////////////////////////////////////////////////////////////
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, xfer_valid, xfer_done, xfer_err, irq, hreadyout, hresp, fail;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0] htrans;
    logic [2:0] hsize, sel; // sel: selector the current scenario uses
    logic [7:0] per_req, per_ack, req_mask;
    logic [3:0] lat;
    dccr_xfer_t xfer_req;
    int fails, samples_checked;
    wire hready = hreadyout; // single slave: its ready is the bus ready
    always #5 hclk = ~hclk;
    dccr_channel dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .per_req(per_req), .per_ack(per_ack),
        .xfer_valid(xfer_valid), .xfer_req(xfer_req), .xfer_done(xfer_done), .xfer_err(xfer_err), .irq(irq));
    dccr_mover far (.hclk(hclk), .hresetn(hresetn), .xfer_valid(xfer_valid), .req_mask(req_mask),
        .lat(lat), .fail(fail), .per_req(per_req), .xfer_done(xfer_done), .xfer_err(xfer_err));
    ////////////////////////////////////////////////////////////////
    // one single word transfer; entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w; hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd_q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, rd_q)
        `CHK("hresp", 1'b0, hresp)
    endtask
    // follow one item from start to acknowledge
    task item(input logic [31:0] a, input logic [1:0] sz);
        while (xfer_valid !== 1'b1) @(posedge hclk);
        `CHK("mem_addr", a, xfer_req.mem_addr)
        `CHK("size", sz, xfer_req.size)
        `CHK("to_periph", sel[0], xfer_req.to_periph)
        `CHK("hold_addr", 32'h4000_0000 + ({29'h0, sel} << 10), xfer_req.hold_addr)
        while (per_ack === 8'h0) @(posedge hclk);
        `CHK("per_ack", 8'h1 << sel, per_ack)
    endtask
    // irq is registered, so give it a short bounded settle
    task wait_irq(input logic v);
        for (int i = 0; i < 4 && irq !== v; i++) @(posedge hclk);
        `CHK("irq", v, irq)
    endtask
    task report_and_stop;
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // reset values, including the write-only control and a hole
    task t_reset;
        logic [7:0] offs [7];
        offs = '{`DCCR_OFF_PTR, `DCCR_OFF_PSEL, `DCCR_OFF_CNT, `DCCR_OFF_RADDR, `DCCR_OFF_RCNT, `DCCR_OFF_CTL, 8'h40};
        foreach (offs[i]) chk_rd("reset", offs[i], 32'h0);
    endtask
    // field widths, upper bits read zero, control and hole read zero
    task t_regs;
        logic [7:0] a [7];
        logic [31:0] d [7];
        logic [31:0] e [7];
        a = '{`DCCR_OFF_PTR, `DCCR_OFF_PSEL, `DCCR_OFF_CNT, `DCCR_OFF_RADDR, `DCCR_OFF_RCNT, `DCCR_OFF_CTL, 8'h40};
        d = '{32'ha5a5_5a5a, 32'hffff_fffd, 32'hffff_1234, 32'h1234_5678, 32'habcd_0001, 32'h0, 32'hffff_ffff};
        e = '{32'ha5a5_5a5a, 32'h5, 32'h1234, 32'h1234_5678, 32'h1, 32'h0, 32'h0};
        foreach (a[i]) begin
            wr(a[i], d[i]);
            chk_rd("regs", a[i], e[i]);
        end
        wr(`DCCR_OFF_RCNT, 32'h0);
    endtask
    // each size code steps the pointer; an empty count with no reload stops
    task t_sizes;
        sel = 3'h1;
        wr(`DCCR_OFF_PSEL, {29'h0, sel});
        // the reserved code 3 is included: it must step like a word
        for (int sz = 0; sz < 4; sz++) begin
            lat <= sz[3:0];
            wr(`DCCR_OFF_MODE, sz);
            wr(`DCCR_OFF_PTR, 32'h1000);
            wr(`DCCR_OFF_CNT, 32'h2);
            wr(`DCCR_OFF_CTL, 32'h1);
            req_mask <= 8'h1 << sel;
            item(32'h1000, sz[1:0]);
            item(32'h1000 + ((sz == 3) ? 32'h4 : (32'h1 << sz)), sz[1:0]);
            repeat (8) @(posedge hclk);
            `CHK("no_more", 1'b0, xfer_valid)
            req_mask <= 8'h0;
            chk_rd("ptr", `DCCR_OFF_PTR, 32'h1000 + ((sz == 3) ? 32'h8 : (32'h2 << sz)));
            chk_rd("cnt", `DCCR_OFF_CNT, 32'h0);
        end
        chk_rd("ctl", `DCCR_OFF_CTL, 32'h0);
        chk_rd("stat", `DCCR_OFF_STAT, 32'h1);
    endtask
    // one-shot reload, then the masked interrupt, then ring reload
    task t_reload;
        wr(`DCCR_OFF_ISTAT, 32'h7);
        wr(`DCCR_OFF_IMASK, 32'h0);
        wr(`DCCR_OFF_MODE, 32'h2);
        wr(`DCCR_OFF_PTR, 32'h100);
        wr(`DCCR_OFF_CNT, 32'h1);
        wr(`DCCR_OFF_RADDR, 32'h2000);
        wr(`DCCR_OFF_RCNT, 32'h2);
        req_mask <= 8'h1 << sel;
        item(32'h100, 2'h2);
        item(32'h2000, 2'h2);
        item(32'h2004, 2'h2);
        repeat (8) @(posedge hclk);
        req_mask <= 8'h0;
        `CHK("one_shot", 1'b0, xfer_valid)
        chk_rd("raddr", `DCCR_OFF_RADDR, 32'h0);
        chk_rd("rcnt", `DCCR_OFF_RCNT, 32'h0);
        chk_rd("ptr", `DCCR_OFF_PTR, 32'h2008);
        `CHK("irq_masked", 1'b0, irq)
        chk_rd("istat", `DCCR_OFF_ISTAT, 32'h3);
        wr(`DCCR_OFF_IMASK, 32'h2);
        wait_irq(1'b1);
        wr(`DCCR_OFF_ISTAT, 32'h2);
        wait_irq(1'b0);
        wr(`DCCR_OFF_MODE, 32'ha);
        wr(`DCCR_OFF_PTR, 32'h300);
        wr(`DCCR_OFF_CNT, 32'h1);
        wr(`DCCR_OFF_RADDR, 32'h3000);
        wr(`DCCR_OFF_RCNT, 32'h1);
        req_mask <= 8'h1 << sel;
        item(32'h300, 2'h2);
        item(32'h3000, 2'h2);
        req_mask <= 8'h0;
        wr(`DCCR_OFF_CTL, 32'h2);
        chk_rd("ring_raddr", `DCCR_OFF_RADDR, 32'h3000);
        chk_rd("ring_rcnt", `DCCR_OFF_RCNT, 32'h1);
    endtask
    // failed item, error clear, stop and go
    task t_fault;
        sel = 3'h2;
        lat <= 4'h1;
        fail <= 1'b1;
        wr(`DCCR_OFF_PSEL, {29'h0, sel});
        wr(`DCCR_OFF_MODE, 32'h0);
        // the ring lap left a reload count behind; drop it so no reload sneaks in
        wr(`DCCR_OFF_RCNT, 32'h0);
        wr(`DCCR_OFF_PTR, 32'h40);
        wr(`DCCR_OFF_CNT, 32'h1);
        wr(`DCCR_OFF_CTL, 32'h1);
        req_mask <= 8'h1 << sel;
        item(32'h40, 2'h0);
        fail <= 1'b0;
        repeat (6) @(posedge hclk);
        `CHK("held", 1'b0, xfer_valid)
        chk_rd("ptr", `DCCR_OFF_PTR, 32'h40);
        chk_rd("cnt", `DCCR_OFF_CNT, 32'h1);
        wr(`DCCR_OFF_CTL, 32'h0);
        chk_rd("stat", `DCCR_OFF_STAT, 32'h3);
        wr(`DCCR_OFF_CTL, 32'h100);
        item(32'h40, 2'h0);
        wr(`DCCR_OFF_CTL, 32'h2);
        wr(`DCCR_OFF_CNT, 32'h3);
        repeat (6) @(posedge hclk);
        `CHK("stopped", 1'b0, xfer_valid)
        chk_rd("stat", `DCCR_OFF_STAT, 32'h0);
        wr(`DCCR_OFF_CTL, 32'h1);
        item(32'h41, 2'h0);
        req_mask <= 8'h0;
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
        hwdata = 32'h0; req_mask = 8'h0; lat = 4'h0; fail = 1'b0; sel = 3'h0; fails = 0; samples_checked = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_regs;
        t_sizes;
        t_reload;
        t_fault;
        report_and_stop;
    end
    // watchdog: the run needs a few thousand cycles at most
    initial begin
        #300us;
        fails++;
        report_and_stop;
    end
endmodule

// file: dccr_consts.svh
// register offsets, field positions and reset values
// assumes a 32-bit word-aligned register bus
`ifndef DCCR_CONSTS_SVH
`define DCCR_CONSTS_SVH
// register byte offsets
`define DCCR_OFF_PTR 8'h00
`define DCCR_OFF_PSEL 8'h04
`define DCCR_OFF_CNT 8'h08
`define DCCR_OFF_RADDR 8'h0c
`define DCCR_OFF_RCNT 8'h10
`define DCCR_OFF_CTL 8'h14
`define DCCR_OFF_MODE 8'h18
`define DCCR_OFF_STAT 8'h1c
`define DCCR_OFF_ISTAT 8'h30
`define DCCR_OFF_IMASK 8'h34
// control bits (write-only)
`define DCCR_CTL_GO 0
`define DCCR_CTL_STOP 1
`define DCCR_CTL_ERROR_CLEAR 8
// mode fields
`define DCCR_MODE_SIZE_LO 0
`define DCCR_MODE_RING 3
// transfer size codes
`define DCCR_SZ_BYTE 2'h0
`define DCCR_SZ_HALF 2'h1
`define DCCR_SZ_WORD 2'h2
// event bits: count empty, reload, fault
`define DCCR_EV_DONE 0
`define DCCR_EV_RLD 1
`define DCCR_EV_FLT 2
`define DCCR_EV_W 3
// reset values
`define DCCR_RST_WORD 32'h0000_0000
`define DCCR_RST_CNT 16'h0000
`endif

// file: dccr_irq.sv
// sticky event flags, mask and level interrupt
// assumes event pulses and bus strobes on the same clock
`timescale 1ns/100ps
`include "dccr_consts.svh"
module dccr_irq (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [`DCCR_EV_W-1:0] ev,
    input wire logic clr_we,
    input wire logic mask_we,
    input wire logic [`DCCR_EV_W-1:0] wdata,
    output logic [`DCCR_EV_W-1:0] stat_r,
    output logic [`DCCR_EV_W-1:0] mask_r,
    output logic irq_r
);
    logic [`DCCR_EV_W-1:0] stat_nxt;
    // a new event beats a write-one-to-clear in the same cycle
    assign stat_nxt = ev | (stat_r & ~(clr_we ? wdata : '0));
    ////////////////////////////////////////////////////////////
    // flags, mask and the registered interrupt line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= '0;
            mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            if (mask_we) begin
                mask_r <= wdata;
            end
            irq_r <= |(stat_nxt & (mask_we ? wdata : mask_r));
        end
    end
endmodule

// file: dccr_mover.sv
// behavioural peripheral and data mover facing one dma channel
// assumes the channel, this model and the bench share hclk and hresetn
`timescale 1ns/100ps
module dccr_mover #(
    parameter int NPER = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic xfer_valid,
    input wire logic [NPER-1:0] req_mask,
    input wire logic [3:0] lat,
    input wire logic fail,
    output logic [NPER-1:0] per_req,
    output logic xfer_done,
    output logic xfer_err
);
    ////////////////////////////////////////////////////////////////
    logic [3:0] wait_r; // cycles spent on the current item
    logic noise_r; // toggles so a stray error level is never stable
    // request levels come straight from the bench
    assign per_req = req_mask;
    // error only means something beside done, elsewhere it wanders
    assign xfer_err = xfer_done ? fail : noise_r;
    ////////////////////////////////////////////////////////////////
    // finish each item after lat extra cycles, one done pulse per item
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_r <= 4'h0;
            xfer_done <= 1'b0;
            noise_r <= 1'b0;
        end else begin
            noise_r <= ~noise_r;
            if (!xfer_valid || xfer_done) begin
                // idle or just finished: no second pulse for one item
                wait_r <= 4'h0;
                xfer_done <= 1'b0;
            end else if (wait_r == lat) begin
                xfer_done <= 1'b1;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// file: dccr_pkg.sv
// types shared by the channel and its helpers
// assumes dccr_consts.svh is on the include path
package dccr_pkg;
    // channel sequencer, gray along idle-busy-idle
    typedef enum logic [0:0] {
        DCCR_IDLE = 1'b0,
        DCCR_BUSY = 1'b1
    } dccr_state_t;
    // one data item handed to the mover
    typedef struct packed {
        logic [31:0] mem_addr;
        logic [31:0] hold_addr;
        logic [1:0] size;
        logic to_periph;
    } dccr_xfer_t;
    // captured ahb address phase
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
    } dccr_aphase_t;
endpackage

// file: dccr_pmap.sv
// peripheral selector decode: handshake line, direction, holding address
// assumes selector comes from a register on the same clock
`timescale 1ns/100ps
module dccr_pmap #(
    parameter int NPER = 8,
    parameter int PSEL_W = 3,
    parameter logic [31:0] HOLD_BASE = 32'h4000_0000
) (
    input wire logic [PSEL_W-1:0] sel,
    output logic [PSEL_W-1:0] hs_idx,
    output logic to_periph,
    output logic [31:0] hold_addr,
    output logic ok
);
    // selector index is the handshake line; odd ids write to the peripheral
    assign hs_idx = sel;
    assign to_periph = sel[0];
    // holding registers sit in 1 KiB peripheral slots
    // slot index scaled by 1 KiB; done at full width so no selector bit is lost
    assign hold_addr = HOLD_BASE + (32'(sel) << 10);
    // ids past the last peripheral never transfer
    assign ok = (32'(sel) < 32'(NPER));
endmodule
